// ===== logic/csf_alarm.sv
// Sub-mode dependent load alarm with sticky latch
`timescale 1ns/10ps
module csf_alarm (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // Conditions
  input  wire logic              active_in,
  input  wire csf_pkg::csf_sub_t sub_in,
  input  wire logic              overload_in,
  input  wire logic              deviation_in,
  input  wire logic              clear_in,
  // Result
  output logic                   alarm_out,
  output logic                   overload_alarm_out,
  output logic                   deviation_alarm_out
);

  logic ovl_r;
  logic ovl_nxt;
  logic dev_r;
  logic dev_nxt;
  logic set_ovl;
  logic set_dev;

  always_comb begin
    set_ovl = 1'b0;
    set_dev = 1'b0;
    if (active_in) begin
      unique case (sub_in)
        csf_pkg::CSF_SUB_POSITION: begin
          set_ovl = overload_in;
          set_dev = deviation_in;
        end
        csf_pkg::CSF_SUB_SPEED: begin
          set_ovl = overload_in;
        end
        // Pressing against the load is the goal, not a fault
        csf_pkg::CSF_SUB_PUSH,
        csf_pkg::CSF_SUB_TORQUE: begin
          set_ovl = 1'b0;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    ovl_nxt = set_ovl | (ovl_r & ~clear_in);
    dev_nxt = set_dev | (dev_r & ~clear_in);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ovl_r <= 1'b0;
      dev_r <= 1'b0;
    end else begin
      ovl_r <= ovl_nxt;
      dev_r <= dev_nxt;
    end
  end

  assign alarm_out           = ovl_r | dev_r;
  assign overload_alarm_out  = ovl_r;
  assign deviation_alarm_out = dev_r;

endmodule

// ===== logic/csf_defines.svh
// Offsets, field positions, reset values and codes of the speed-follow block
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// Object indices
`define CSF_IDX_CONTROL     16'h6040
`define CSF_IDX_STATUS      16'h6041
`define CSF_IDX_MODE_SEL    16'h6060
`define CSF_IDX_MODE_SHOWN  16'h6061
`define CSF_IDX_VEL_DEMAND  16'h606b
`define CSF_IDX_VEL_MEAS    16'h606c
`define CSF_IDX_VEL_TARGET  16'h60ff

// Reset values
`define CSF_CONTROL_RST     16'h0000
`define CSF_MODE_SEL_RST    8'h00
`define CSF_VEL_TARGET_RST  32'h00000000

// Mode code that selects cyclic speed-follow operation
`define CSF_MODE_CODE       8'h09

// Accepted target range, -4,000,000 .. 4,000,000 Hz
`define CSF_VEL_MAX         32'h003d0900
`define CSF_VEL_MIN         32'hffc2f700

// Control word fields
`define CSF_CW_HALT         8
`define CSF_CW_FAULT_RST    7
`define CSF_CW_TYPE_HI      13
`define CSF_CW_TYPE_LO      12
`define CSF_CW_USED_MASK    16'h318f

// Status word fields
`define CSF_SW_TORQUE_LIM   15
`define CSF_SW_TGT_FOLLOW   12
`define CSF_SW_LIMIT        11
`define CSF_SW_REMOTE       9
`define CSF_SW_FAULT        3
`define CSF_SW_OP_ENABLED   2

`endif

// ===== logic/csf_pkg.sv
// Types shared by the speed-follow block
package csf_pkg;

  // Sub-mode in control word bits 13:12, in field order 00..11
  typedef enum logic [1:0] {
    CSF_SUB_POSITION,
    CSF_SUB_SPEED,
    CSF_SUB_PUSH,
    CSF_SUB_TORQUE
  } csf_sub_t;

  // Cyclic data from the master
  typedef struct packed {
    logic [15:0]        control_word;
    logic [7:0]         mode_select;
    logic signed [31:0] velocity_target;
  } csf_rx_pdo_t;

  // Cyclic data to the master
  typedef struct packed {
    logic [15:0]        status_word;
    logic [7:0]         mode_shown;
    logic signed [31:0] velocity_demand;
    logic signed [31:0] velocity_measured;
  } csf_tx_pdo_t;

  // Commands to the power stage
  typedef struct packed {
    logic signed [31:0] velocity;
    logic               position_loop;
    logic               push_hold;
    logic               immediate_stop;
  } csf_motor_cmd_t;

endpackage

// ===== logic/csf_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module csf_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          meta_r[i] <= 1'b0;
          hold_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          hold_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = hold_r;

endmodule

// ===== logic/csf_top.sv
// Cyclic speed-follow command handling: process data, objects, sub-modes, stop
`timescale 1ns/10ps
`include "csf_defines.svh"

module csf_top (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  // Cyclic data from the master
  input  wire logic                    rx_pdo_valid_in,
  input  wire csf_pkg::csf_rx_pdo_t    rx_pdo_in,
  // Cyclic data to the master
  output csf_pkg::csf_tx_pdo_t         tx_pdo_out,
  // Acyclic object access
  input  wire logic                    obj_req_in,
  input  wire logic                    obj_wr_in,
  input  wire logic [15:0]             obj_index_in,
  input  wire logic [31:0]             obj_wdata_in,
  output logic                         obj_ack_out,
  output logic                         obj_err_out,
  output logic [31:0]                  obj_rdata_out,
  // Drive state machine, same clock
  input  wire logic                    op_enabled_in,
  // Power stage, same clock
  input  wire logic signed [31:0]      motor_vel_in,
  output csf_pkg::csf_motor_cmd_t      motor_cmd_out,
  // Pins
  input  wire logic                    stop_pin_in,
  input  wire logic                    limit_pin_in,
  input  wire logic                    overload_pin_in,
  input  wire logic                    deviation_pin_in,
  // Alarm state
  output logic                         alarm_out
);

  // Stored objects
  logic [15:0]                  control_word_r;
  logic [15:0]                  control_word_nxt;
  logic [7:0]                   mode_select_r;
  logic [7:0]                   mode_select_nxt;
  logic signed [31:0]           velocity_target_r;
  logic signed [31:0]           velocity_target_nxt;
  logic                         remote_r;
  logic                         fault_rst_prev_r;
  logic                         fault_rst_prev_nxt;

  // Answers and outputs
  logic                         obj_ack_r;
  logic                         obj_ack_nxt;
  logic                         obj_err_r;
  logic                         obj_err_nxt;
  logic [31:0]                  obj_rdata_r;
  logic [31:0]                  obj_rdata_nxt;
  csf_pkg::csf_tx_pdo_t         tx_pdo_r;
  csf_pkg::csf_tx_pdo_t         tx_pdo_nxt;
  csf_pkg::csf_motor_cmd_t      motor_cmd_r;
  csf_pkg::csf_motor_cmd_t      motor_cmd_nxt;
  logic                         alarm_r;

  // Working signals
  logic [3:0]                   pins_sync;
  logic                         stop_pin;
  logic                         limit_pin;
  logic                         overload_pin;
  logic                         deviation_pin;
  csf_pkg::csf_sub_t            sub_mode;
  logic                         mode_active;
  logic                         halt_req;
  logic                         following;
  logic                         fault_clear;
  logic                         alarm_any;
  logic [15:0]                  status_word;
  logic signed [31:0]           velocity_demand;

  csf_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({deviation_pin_in, overload_pin_in, limit_pin_in, stop_pin_in}),
    .sync_out   (pins_sync)
  );

  assign stop_pin      = pins_sync[0];
  assign limit_pin     = pins_sync[1];
  assign overload_pin  = pins_sync[2];
  assign deviation_pin = pins_sync[3];

  // Range test used by both write paths
  function automatic logic vel_in_range(input logic signed [31:0] v);
    vel_in_range = (v <= $signed(`CSF_VEL_MAX)) && (v >= $signed(`CSF_VEL_MIN));
  endfunction

  // Sub-mode decoded straight from the live control word
  assign sub_mode    = csf_pkg::csf_sub_t'(
                         control_word_r[`CSF_CW_TYPE_HI:`CSF_CW_TYPE_LO]);
  assign mode_active = (mode_select_r == `CSF_MODE_CODE);
  assign halt_req    = control_word_r[`CSF_CW_HALT];
  // Fault reset acts on the rising edge of the control bit
  assign fault_clear = control_word_r[`CSF_CW_FAULT_RST] & ~fault_rst_prev_r;

  // Target is followed only when nothing blocks it
  assign following = mode_active & op_enabled_in & ~halt_req & ~stop_pin
                     & ~limit_pin & ~alarm_any;
  // No internal profile: the target is taken as the demand as it stands
  assign velocity_demand = following ? velocity_target_r : 32'sh00000000;

  csf_alarm u_alarm (
    .clk_sys_in          (clk_sys_in),
    .rst_in              (rst_in),
    .active_in           (mode_active & op_enabled_in),
    .sub_in              (sub_mode),
    .overload_in         (overload_pin),
    .deviation_in        (deviation_pin),
    .clear_in            (fault_clear),
    .alarm_out           (alarm_any),
    .overload_alarm_out  (),
    .deviation_alarm_out ()
  );

  // Status word; drive state bits beyond these are kept elsewhere
  always_comb begin
    status_word                      = 16'h0000;
    status_word[`CSF_SW_TORQUE_LIM]  = overload_pin & mode_active;
    status_word[`CSF_SW_TGT_FOLLOW]  = following;
    status_word[`CSF_SW_LIMIT]       = limit_pin;
    status_word[`CSF_SW_REMOTE]      = remote_r;
    status_word[`CSF_SW_FAULT]       = alarm_any;
    status_word[`CSF_SW_OP_ENABLED]  = op_enabled_in;
  end

  // Object store: cyclic data and acyclic access
  always_comb begin
    control_word_nxt    = control_word_r;
    mode_select_nxt     = mode_select_r;
    velocity_target_nxt = velocity_target_r;
    fault_rst_prev_nxt  = control_word_r[`CSF_CW_FAULT_RST];
    obj_ack_nxt         = 1'b0;
    obj_err_nxt         = 1'b0;
    obj_rdata_nxt       = obj_rdata_r;

    if (rx_pdo_valid_in) begin
      // Unused bits dropped so they can never steer motion
      control_word_nxt = rx_pdo_in.control_word & `CSF_CW_USED_MASK;
      mode_select_nxt  = rx_pdo_in.mode_select;
      if (vel_in_range(rx_pdo_in.velocity_target)) begin
        velocity_target_nxt = rx_pdo_in.velocity_target;
      end
    end

    if (obj_req_in) begin
      obj_ack_nxt   = 1'b1;
      obj_rdata_nxt = 32'h00000000;
      if (obj_wr_in) begin
        unique case (obj_index_in)
          `CSF_IDX_CONTROL: begin
            control_word_nxt = obj_wdata_in[15:0] & `CSF_CW_USED_MASK;
          end
          `CSF_IDX_MODE_SEL: begin
            mode_select_nxt = obj_wdata_in[7:0];
          end
          `CSF_IDX_VEL_TARGET: begin
            if (vel_in_range(obj_wdata_in)) begin
              velocity_target_nxt = obj_wdata_in;
            end else begin
              obj_err_nxt = 1'b1;
            end
          end
          // Read-only or unmapped index
          default: begin
            obj_err_nxt = 1'b1;
          end
        endcase
      end else begin
        unique case (obj_index_in)
          `CSF_IDX_CONTROL:    obj_rdata_nxt = {16'h0000, control_word_r};
          `CSF_IDX_STATUS:     obj_rdata_nxt = {16'h0000, status_word};
          `CSF_IDX_MODE_SEL:   obj_rdata_nxt = {24'h000000, mode_select_r};
          `CSF_IDX_MODE_SHOWN: obj_rdata_nxt = {24'h000000, mode_select_r};
          `CSF_IDX_VEL_DEMAND: obj_rdata_nxt = tx_pdo_r.velocity_demand;
          `CSF_IDX_VEL_MEAS:   obj_rdata_nxt = tx_pdo_r.velocity_measured;
          `CSF_IDX_VEL_TARGET: obj_rdata_nxt = velocity_target_r;
          default:             obj_err_nxt   = 1'b1;
        endcase
      end
    end
  end

  // Outputs to master and power stage
  always_comb begin
    tx_pdo_nxt.status_word       = status_word;
    tx_pdo_nxt.mode_shown        = mode_select_r;
    tx_pdo_nxt.velocity_demand   = velocity_demand;
    tx_pdo_nxt.velocity_measured = motor_vel_in;

    motor_cmd_nxt.velocity       = velocity_demand;
    motor_cmd_nxt.immediate_stop = mode_active & halt_req;
    motor_cmd_nxt.position_loop  = 1'b0;
    motor_cmd_nxt.push_hold      = 1'b0;
    unique case (sub_mode)
      csf_pkg::CSF_SUB_POSITION: motor_cmd_nxt.position_loop = mode_active;
      csf_pkg::CSF_SUB_SPEED:    motor_cmd_nxt.position_loop = 1'b0;
      csf_pkg::CSF_SUB_PUSH:     motor_cmd_nxt.push_hold     = mode_active;
      csf_pkg::CSF_SUB_TORQUE:   motor_cmd_nxt.push_hold     = mode_active;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      control_word_r    <= `CSF_CONTROL_RST;
      mode_select_r     <= `CSF_MODE_SEL_RST;
      velocity_target_r <= `CSF_VEL_TARGET_RST;
      fault_rst_prev_r  <= 1'b0;
      remote_r          <= 1'b0;
      obj_ack_r         <= 1'b0;
      obj_err_r         <= 1'b0;
      obj_rdata_r       <= 32'h00000000;
      tx_pdo_r          <= '0;
      motor_cmd_r       <= '0;
      alarm_r           <= 1'b0;
    end else begin
      control_word_r    <= control_word_nxt;
      mode_select_r     <= mode_select_nxt;
      velocity_target_r <= velocity_target_nxt;
      fault_rst_prev_r  <= fault_rst_prev_nxt;
      remote_r          <= 1'b1;
      obj_ack_r         <= obj_ack_nxt;
      obj_err_r         <= obj_err_nxt;
      obj_rdata_r       <= obj_rdata_nxt;
      tx_pdo_r          <= tx_pdo_nxt;
      motor_cmd_r       <= motor_cmd_nxt;
      alarm_r           <= alarm_any;
    end
  end

  assign tx_pdo_out    = tx_pdo_r;
  assign motor_cmd_out = motor_cmd_r;
  assign obj_ack_out   = obj_ack_r;
  assign obj_err_out   = obj_err_r;
  assign obj_rdata_out = obj_rdata_r;
  assign alarm_out     = alarm_r;

endmodule

// ===== tb/csf_master_model.sv
// Cyclic master: sends control word, mode and target every period
`timescale 1ns/10ps
module csf_master_model (
  // Clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  // Frame content and spacing, 1 gives back-to-back frames
  input  wire logic [7:0]         period_in,
  input  wire logic [15:0]        cw_in,
  input  wire logic [7:0]         mode_in,
  input  wire logic signed [31:0] target_in,
  // Cyclic output
  output logic                    rx_pdo_valid_out,
  output csf_pkg::csf_rx_pdo_t    rx_pdo_out
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
      rx_pdo_valid_out <= 1'b0;
      rx_pdo_out <= '0;
    end else begin
      cnt_r <= (cnt_r + 8'h01 >= period_in) ? 8'h00 : cnt_r + 8'h01;
      rx_pdo_valid_out <= (cnt_r == 8'h00);
      // Whole profile made here; data toggles between frames to expose stale use
      rx_pdo_out <= (cnt_r == 8'h00) ? {cw_in, mode_in, target_in} : ~rx_pdo_out;
    end
  end
endmodule

// ===== tb/csf_top_asserts.sv
// Port assertions of the speed-follow block
`timescale 1ns/10ps
`include "csf_defines.svh"
module csf_top_asserts (
  // Clock and reset
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  // Watched ports
  input wire logic                    rx_pdo_valid_in,
  input wire csf_pkg::csf_rx_pdo_t    rx_pdo_in,
  input wire logic                    obj_req_in,
  input wire logic                    op_enabled_in,
  input wire logic signed [31:0]      motor_vel_in,
  input wire csf_pkg::csf_tx_pdo_t    tx_pdo_out,
  input wire logic                    obj_ack_out,
  input wire csf_pkg::csf_motor_cmd_t motor_cmd_out
);
  // Edges since reset; sync flops need a few before frames count
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  always_comb begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      up_r <= 3'h0;
    end else begin
      up_r <= up_nxt;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_frame;
    rx_pdo_valid_in && !obj_req_in && up_r > 3'h3 && rx_pdo_in.mode_select == `CSF_MODE_CODE;
  endsequence
  property p_ack_next;
    obj_req_in |=> obj_ack_out;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request without answer");
  property p_demand_gate;
    !tx_pdo_out.status_word[12] |-> tx_pdo_out.velocity_demand == 32'sh0;
  endproperty
  a_demand_gate: assert property (p_demand_gate) else $error("demand while not following");
  property p_follow_cmd;
    tx_pdo_out.status_word[12] |-> motor_cmd_out.velocity == tx_pdo_out.velocity_demand;
  endproperty
  a_follow_cmd: assert property (p_follow_cmd) else $error("motor speed not demand");
  property p_stop_zero;
    motor_cmd_out.immediate_stop |->
      motor_cmd_out.velocity == 32'sh0 && !tx_pdo_out.status_word[12];
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("speed during stop");
  property p_push_excl;
    motor_cmd_out.push_hold |-> !motor_cmd_out.position_loop;
  endproperty
  a_push_excl: assert property (p_push_excl) else $error("push with position loop");
  property p_halt_frame;
    s_frame ##0 rx_pdo_in.control_word[8] |-> ##2 motor_cmd_out.immediate_stop;
  endproperty
  a_halt_frame: assert property (p_halt_frame) else $error("halt not applied");
  property p_sub_frame;
    s_frame ##0 (op_enabled_in && !rx_pdo_in.control_word[8]) |-> ##2
      motor_cmd_out.push_hold == $past(rx_pdo_in.control_word[13], 2) &&
      motor_cmd_out.position_loop == ($past(rx_pdo_in.control_word[13:12], 2) == 2'h0);
  endproperty
  a_sub_frame: assert property (p_sub_frame) else $error("sub-mode not applied");
  property p_measured;
    $stable(motor_vel_in)[*3] ##0 up_r == 3'h7 |-> tx_pdo_out.velocity_measured == motor_vel_in;
  endproperty
  a_measured: assert property (p_measured) else $error("measured speed wrong");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the speed-follow block
`timescale 1ns/10ps
`include "csf_defines.svh"
module tb_top;
  logic                    clk_sys_in = 1'b0;
  logic                    rst_in     = 1'b1;
  logic                    mdl_rst    = 1'b1;
  logic                    pdo_v;
  csf_pkg::csf_rx_pdo_t    rx_pdo;
  csf_pkg::csf_tx_pdo_t    tx;
  csf_pkg::csf_motor_cmd_t mc;
  logic                    req        = 1'b0;
  logic                    wr         = 1'b0;
  logic [15:0]             idx        = 16'h0000;
  logic [31:0]             wd         = 32'h00000000;
  logic [31:0]             rd;
  logic                    ack;
  logic                    err;
  logic                    op_en      = 1'b0;
  logic signed [31:0]      mvel       = 32'sh0;
  logic [3:0]              pins       = 4'h0;
  logic                    alarm;
  logic [7:0]              period     = 8'h04;
  logic [15:0]             cw         = 16'h0000;
  logic [7:0]              mode       = 8'h00;
  logic signed [31:0]      tgt        = 32'sh0;
  int                      err_total  = 0;
  int                      n_compared = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  csf_master_model mdl (.clk_sys_in(clk_sys_in), .rst_in(mdl_rst), .period_in(period),
    .cw_in(cw), .mode_in(mode), .target_in(tgt), .rx_pdo_valid_out(pdo_v), .rx_pdo_out(rx_pdo));
  csf_top uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rx_pdo_valid_in(pdo_v),
    .rx_pdo_in(rx_pdo), .tx_pdo_out(tx), .obj_req_in(req), .obj_wr_in(wr), .obj_index_in(idx),
    .obj_wdata_in(wd), .obj_ack_out(ack), .obj_err_out(err), .obj_rdata_out(rd),
    .op_enabled_in(op_en), .motor_vel_in(mvel), .motor_cmd_out(mc), .stop_pin_in(pins[3]),
    .limit_pin_in(pins[2]), .overload_pin_in(pins[1]), .deviation_pin_in(pins[0]),
    .alarm_out(alarm));
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Answer comes on the taking edge itself, checked just after it
  task automatic obj(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic e, input logic [31:0] r);
    @(posedge clk_sys_in);
    req <= 1'b1;
    wr <= w;
    idx <= i;
    wd <= d;
    @(posedge clk_sys_in);
    req <= 1'b0;
    #1;
    chk(ack, 1'b1);
    chk(err, e);
    if (!w) chk(rd, r);
  endtask
  task automatic frames(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 200 && seen < n; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (pdo_v === 1'b1) seen++;
    end
    if (seen < n) begin
      err_total++;
      complete_run();
    end
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic send(input logic [15:0] c, input logic signed [31:0] t);
    @(posedge clk_sys_in);
    cw <= c;
    tgt <= t;
    frames(2);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    obj(1'b0, `CSF_IDX_CONTROL, 32'h0, 1'b0, 32'h0);
    obj(1'b0, `CSF_IDX_MODE_SEL, 32'h0, 1'b0, 32'h0);
    obj(1'b0, `CSF_IDX_VEL_TARGET, 32'h0, 1'b0, 32'h0);
    obj(1'b0, 16'h1234, 32'h0, 1'b1, 32'h0);
    obj(1'b1, `CSF_IDX_VEL_DEMAND, 32'h5, 1'b1, 32'h0);
    obj(1'b1, `CSF_IDX_STATUS, 32'h5, 1'b1, 32'h0);
    obj(1'b0, `CSF_IDX_VEL_MEAS, 32'h0, 1'b0, 32'h0);
    obj(1'b1, `CSF_IDX_CONTROL, 32'hffff, 1'b0, 32'h0);
    obj(1'b0, `CSF_IDX_CONTROL, 32'h0, 1'b0, 32'h318f);
    obj(1'b1, `CSF_IDX_VEL_TARGET, 32'h003d0900, 1'b0, 32'h0);
    obj(1'b1, `CSF_IDX_VEL_TARGET, 32'h003d0901, 1'b1, 32'h0);
    obj(1'b0, `CSF_IDX_VEL_TARGET, 32'h0, 1'b0, 32'h003d0900);
    obj(1'b1, `CSF_IDX_VEL_TARGET, 32'hffc2f6ff, 1'b1, 32'h0);
    obj(1'b1, `CSF_IDX_VEL_TARGET, 32'hffc2f700, 1'b0, 32'h0);
    obj(1'b1, `CSF_IDX_MODE_SEL, 32'h9, 1'b0, 32'h0);
    obj(1'b0, `CSF_IDX_MODE_SHOWN, 32'h0, 1'b0, 32'h9);
    @(posedge clk_sys_in);
    op_en <= 1'b1;
    obj(1'b1, `CSF_IDX_CONTROL, 32'h000f, 1'b0, 32'h0);
    obj(1'b0, `CSF_IDX_VEL_DEMAND, 32'h0, 1'b0, 32'hffc2f700);
    @(posedge clk_sys_in);
    mode <= `CSF_MODE_CODE;
    mdl_rst <= 1'b0;
    send(16'h000f, 32'sd500);
    chk(tx.velocity_demand, 32'sd500);
    chk(mc.velocity, 32'sd500);
    send(16'h000f, 32'sd4000001);
    chk(tx.velocity_demand, 32'sd500);
    @(posedge clk_sys_in);
    period <= 8'h01;
    send(16'h000f, -32'sd7);
    for (int s = 0; s < 4; s++) begin
      send({2'b00, s[1:0], 12'h00f}, -32'sd7);
      chk(mc.position_loop, s == 0);
      chk(mc.push_hold, s >= 2);
      chk(tx.velocity_demand, -32'sd7);
    end
    // Back off from the load before leaving push; current left at push level
    send(16'h300f, 32'sd7);
    chk(mc.push_hold, 1'b1);
    chk(mc.velocity, 32'sd7);
    send(16'h010f, -32'sd7);
    chk(mc.immediate_stop, 1'b1);
    chk(mc.velocity, 32'sh0);
    send(16'hc40f, -32'sd7);
    chk(mc.immediate_stop, 1'b0);
    chk(tx.velocity_demand, -32'sd7);
    @(posedge clk_sys_in);
    pins <= 4'hc;
    mvel <= -32'sd1234;
    repeat (5) @(posedge clk_sys_in);
    #1;
    chk(tx.velocity_demand, 32'sh0);
    chk(tx.status_word[11], 1'b1);
    chk(tx.status_word[12], 1'b0);
    chk(tx.status_word[9], 1'b1);
    chk(tx.velocity_measured, -32'sd1234);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        send({2'b00, s[1:0], 12'h00f}, -32'sd7);
        @(posedge clk_sys_in);
        pins <= (p == 0) ? 4'h2 : 4'h1;
        repeat (6) @(posedge clk_sys_in);
        #1;
        chk(alarm, s == 0 || (s == 1 && p == 0));
        chk(tx.status_word[3], s == 0 || (s == 1 && p == 0));
        chk(tx.status_word[15], p == 0);
        @(posedge clk_sys_in);
        pins <= 4'h0;
        send({2'b00, s[1:0], 12'h08f}, -32'sd7);
        send({2'b00, s[1:0], 12'h00f}, -32'sd7);
        chk(alarm, 1'b0);
      end
    end
    complete_run();
  end
endmodule
bind csf_top csf_top_asserts chk_i (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .rx_pdo_valid_in(rx_pdo_valid_in),
  .rx_pdo_in(rx_pdo_in),
  .obj_req_in(obj_req_in),
  .op_enabled_in(op_enabled_in),
  .motor_vel_in(motor_vel_in),
  .tx_pdo_out(tx_pdo_out),
  .obj_ack_out(obj_ack_out),
  .motor_cmd_out(motor_cmd_out)
);
